// [core/iprb_bank.sv]
// Purpose: bank of five interrupt priority registers plus source enables
// Assumes: plain strobe register port, read data valid the cycle after rd
// Notes: levels and gated levels go straight to the arbitration logic
//
// Notes on behaviour
// - each field is three bits; code 111 means level seven, the highest.
// - code 001 is level one, lowest active; codes between map linearly.
// - code 000 disables the source so it never requests.
// - unimplemented bits always read back as zero.
// - reset puts every field at level four, unimplemented bits zero.
// - implemented field bits are read/write and hold until reset.
// - first register: dma1 10-8, adc1 6-4, uart1 tx 2-0.
// - second register: change notify 14-12, i2c1 master 6-4, slave 2-0.
// - third register: capture8 14-12, capture7 10-8, adc2 6-4, ext1 2-0.
// - fourth register: timer4 14-12, compare4 10-8, compare3 6-4, dma2 2-0.
// - fifth register: uart2 tx 14-12, uart2 rx 10-8, ext2 6-4, timer5 2-0.
// - four-field registers leave bits 15, 11, 7 and 3 unused.
// - a cleared per-source enable blocks the request regardless of level.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module iprb_bank (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [2:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic [17:0] src_enable_out,
  output logic [53:0] src_level_out,
  output logic [53:0] src_gated_level_out,
  output logic [17:0] src_active_out
);

  iprb_pkg::iprb_req_s req;
  logic [15:0] reg3_val;
  logic [15:0] reg4_val;
  logic [15:0] reg5_val;
  logic [15:0] reg6_val;
  logic [15:0] reg7_val;
  logic [15:0] ena_lo_val;
  logic [15:0] ena_hi_val;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [15:0] read_mux;
  logic [4:0] wr_sel;
  logic wr_ena_lo;
  logic wr_ena_hi;
  logic [17:0] enable_vec;
  logic [53:0] level_vec;

  // extract a three-bit field whose low bit sits at pos
  function automatic iprb_pkg::iprb_level_t field_at(input logic [15:0] word,
                                                     input int unsigned pos);
    field_at = word[pos +: 3];
  endfunction

  // a source may request only with nonzero level and enable set
  function automatic logic level_active(input iprb_pkg::iprb_level_t lvl,
                                        input logic ena);
    level_active = ena && (lvl != iprb_pkg::IPRB_LVL_OFF);
  endfunction

  // bundle the port into one request word
  assign req.addr = addr_in;
  assign req.wdata = wdata_in;
  assign req.wr = wr_in;
  assign req.rd = rd_in;

  // write decode, one strobe per register
  assign wr_sel[0] = req.wr && (req.addr == iprb_pkg::IPRB_OFF_DMA1_ADC1_UART1TX);
  assign wr_sel[1] = req.wr && (req.addr == iprb_pkg::IPRB_OFF_CHANGENOTIFY_I2C1);
  assign wr_sel[2] = req.wr && (req.addr == iprb_pkg::IPRB_OFF_CAPTURE_ADC2_EXT1);
  assign wr_sel[3] = req.wr && (req.addr == iprb_pkg::IPRB_OFF_TIMER4_COMPARE_DMA2);
  assign wr_sel[4] = req.wr && (req.addr == iprb_pkg::IPRB_OFF_UART2_EXT2_TIMER5);
  assign wr_ena_lo = req.wr && (req.addr == iprb_pkg::IPRB_OFF_ENABLE_LO);
  assign wr_ena_hi = req.wr && (req.addr == iprb_pkg::IPRB_OFF_ENABLE_HI);

  iprb_reg16 #(
    .MASK(iprb_pkg::IPRB_MASK_REG3),
    .RESET_VALUE(iprb_pkg::IPRB_RST_REG3)
  ) u_priority_dma1_adc1_uart1tx (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(wr_sel[0]),
    .wdata_in(req.wdata),
    .value_out(reg3_val)
  );

  iprb_reg16 #(
    .MASK(iprb_pkg::IPRB_MASK_REG4),
    .RESET_VALUE(iprb_pkg::IPRB_RST_REG4)
  ) u_priority_changenotify_i2c1 (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(wr_sel[1]),
    .wdata_in(req.wdata),
    .value_out(reg4_val)
  );

  iprb_reg16 #(
    .MASK(iprb_pkg::IPRB_MASK_FOUR),
    .RESET_VALUE(iprb_pkg::IPRB_RST_FOUR)
  ) u_priority_capture_adc2_ext1 (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(wr_sel[2]),
    .wdata_in(req.wdata),
    .value_out(reg5_val)
  );

  iprb_reg16 #(
    .MASK(iprb_pkg::IPRB_MASK_FOUR),
    .RESET_VALUE(iprb_pkg::IPRB_RST_FOUR)
  ) u_priority_timer4_compare_dma2 (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(wr_sel[3]),
    .wdata_in(req.wdata),
    .value_out(reg6_val)
  );

  iprb_reg16 #(
    .MASK(iprb_pkg::IPRB_MASK_FOUR),
    .RESET_VALUE(iprb_pkg::IPRB_RST_FOUR)
  ) u_priority_uart2_ext2_timer5 (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(wr_sel[4]),
    .wdata_in(req.wdata),
    .value_out(reg7_val)
  );

  // source enables
  // enables reset cleared so nothing requests before software sets it up
  iprb_reg16 #(
    .MASK(iprb_pkg::IPRB_MASK_ENA_LO),
    .RESET_VALUE(iprb_pkg::IPRB_RST_ENA)
  ) u_enable_lo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(wr_ena_lo),
    .wdata_in(req.wdata),
    .value_out(ena_lo_val)
  );

  iprb_reg16 #(
    .MASK(iprb_pkg::IPRB_MASK_ENA_HI),
    .RESET_VALUE(iprb_pkg::IPRB_RST_ENA)
  ) u_enable_hi (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(wr_ena_hi),
    .wdata_in(req.wdata),
    .value_out(ena_hi_val)
  );

  assign enable_vec = {ena_hi_val[1:0], ena_lo_val};

  assign read_mux =
    (req.addr == iprb_pkg::IPRB_OFF_DMA1_ADC1_UART1TX) ? reg3_val :
    (req.addr == iprb_pkg::IPRB_OFF_CHANGENOTIFY_I2C1) ? reg4_val :
    (req.addr == iprb_pkg::IPRB_OFF_CAPTURE_ADC2_EXT1) ? reg5_val :
    (req.addr == iprb_pkg::IPRB_OFF_TIMER4_COMPARE_DMA2) ? reg6_val :
    (req.addr == iprb_pkg::IPRB_OFF_UART2_EXT2_TIMER5) ? reg7_val :
    (req.addr == iprb_pkg::IPRB_OFF_ENABLE_LO) ? ena_lo_val :
    (req.addr == iprb_pkg::IPRB_OFF_ENABLE_HI) ? ena_hi_val :
    16'h0000;

  // read data holds only in the cycle after the strobe, zero otherwise
  assign rdata_next = req.rd ? read_mux : 16'h0000;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;

  // three-bit levels
  // levels pass through untouched; 111 is the top, 001 the bottom
  assign level_vec[2:0] = field_at(reg3_val, iprb_pkg::IPRB_POS_F0);
  assign level_vec[5:3] = field_at(reg3_val, iprb_pkg::IPRB_POS_F1);
  assign level_vec[8:6] = field_at(reg3_val, iprb_pkg::IPRB_POS_F2);
  assign level_vec[11:9] = field_at(reg4_val, iprb_pkg::IPRB_POS_F0);
  assign level_vec[14:12] = field_at(reg4_val, iprb_pkg::IPRB_POS_F1);
  assign level_vec[17:15] = field_at(reg4_val, iprb_pkg::IPRB_POS_F3);
  assign level_vec[20:18] = field_at(reg5_val, iprb_pkg::IPRB_POS_F0);
  assign level_vec[23:21] = field_at(reg5_val, iprb_pkg::IPRB_POS_F1);
  assign level_vec[26:24] = field_at(reg5_val, iprb_pkg::IPRB_POS_F2);
  assign level_vec[29:27] = field_at(reg5_val, iprb_pkg::IPRB_POS_F3);
  assign level_vec[32:30] = field_at(reg6_val, iprb_pkg::IPRB_POS_F0);
  assign level_vec[35:33] = field_at(reg6_val, iprb_pkg::IPRB_POS_F1);
  assign level_vec[38:36] = field_at(reg6_val, iprb_pkg::IPRB_POS_F2);
  assign level_vec[41:39] = field_at(reg6_val, iprb_pkg::IPRB_POS_F3);
  assign level_vec[44:42] = field_at(reg7_val, iprb_pkg::IPRB_POS_F0);
  assign level_vec[47:45] = field_at(reg7_val, iprb_pkg::IPRB_POS_F1);
  assign level_vec[50:48] = field_at(reg7_val, iprb_pkg::IPRB_POS_F2);
  assign level_vec[53:51] = field_at(reg7_val, iprb_pkg::IPRB_POS_F3);

  assign src_level_out = level_vec;
  assign src_enable_out = enable_vec;

  genvar gi;
  generate
    for (gi = 0; gi < 18; gi++) begin : g_src
      assign src_active_out[gi] = level_active(level_vec[gi*3 +: 3], enable_vec[gi]);
      assign src_gated_level_out[gi*3 +: 3] =
        src_active_out[gi] ? level_vec[gi*3 +: 3] : iprb_pkg::IPRB_LVL_OFF;
    end
  endgenerate

endmodule

// [core/iprb_pkg.sv]
// Purpose: shared constants and types for the interrupt priority bank
// Assumes: 16-bit registers on a plain strobe port, word index addressing
// Notes: one field is three bits; zero disables its source
package iprb_pkg;

  localparam int unsigned IPRB_ADDR_W = 3;
  localparam int unsigned IPRB_DATA_W = 16;
  localparam int unsigned IPRB_NUM_REGS = 5;
  localparam int unsigned IPRB_NUM_SRC = 18;
  localparam int unsigned IPRB_LVL_W = 3;

  // register offsets, word index on the register port
  localparam logic [2:0] IPRB_OFF_DMA1_ADC1_UART1TX = 3'h0;
  localparam logic [2:0] IPRB_OFF_CHANGENOTIFY_I2C1 = 3'h1;
  localparam logic [2:0] IPRB_OFF_CAPTURE_ADC2_EXT1 = 3'h2;
  localparam logic [2:0] IPRB_OFF_TIMER4_COMPARE_DMA2 = 3'h3;
  localparam logic [2:0] IPRB_OFF_UART2_EXT2_TIMER5 = 3'h4;
  localparam logic [2:0] IPRB_OFF_ENABLE_LO = 3'h5;
  localparam logic [2:0] IPRB_OFF_ENABLE_HI = 3'h6;

  // implemented-bit masks for each priority register
  localparam logic [15:0] IPRB_MASK_REG3 = 16'h0777;
  localparam logic [15:0] IPRB_MASK_REG4 = 16'h7077;
  localparam logic [15:0] IPRB_MASK_FOUR = 16'h7777;
  localparam logic [15:0] IPRB_MASK_ENA_LO = 16'hffff;
  localparam logic [15:0] IPRB_MASK_ENA_HI = 16'h0003;

  // field low-bit positions
  localparam int unsigned IPRB_POS_F3 = 12;
  localparam int unsigned IPRB_POS_F2 = 8;
  localparam int unsigned IPRB_POS_F1 = 4;
  localparam int unsigned IPRB_POS_F0 = 0;

  // reset values: upper field bit set, level 4; enables reset to zero
  localparam logic [2:0] IPRB_LVL_RESET = 3'h4;
  localparam logic [2:0] IPRB_LVL_OFF = 3'h0;
  localparam logic [15:0] IPRB_RST_REG3 = 16'h0444;
  localparam logic [15:0] IPRB_RST_REG4 = 16'h4044;
  localparam logic [15:0] IPRB_RST_FOUR = 16'h4444;
  localparam logic [15:0] IPRB_RST_ENA = 16'h0000;

  typedef logic [2:0] iprb_level_t;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } iprb_req_s;

  // source index order on the level and gate vectors
  typedef enum logic [4:0] {
    IPRB_SRC_UART1_TX = 5'h00,
    IPRB_SRC_ADC1 = 5'h01,
    IPRB_SRC_DMA1 = 5'h02,
    IPRB_SRC_I2C1_SLAVE = 5'h03,
    IPRB_SRC_I2C1_MASTER = 5'h04,
    IPRB_SRC_CHANGE_NOTIFY = 5'h05,
    IPRB_SRC_EXT1 = 5'h06,
    IPRB_SRC_ADC2 = 5'h07,
    IPRB_SRC_CAPTURE7 = 5'h08,
    IPRB_SRC_CAPTURE8 = 5'h09,
    IPRB_SRC_DMA2 = 5'h0a,
    IPRB_SRC_COMPARE3 = 5'h0b,
    IPRB_SRC_COMPARE4 = 5'h0c,
    IPRB_SRC_TIMER4 = 5'h0d,
    IPRB_SRC_TIMER5 = 5'h0e,
    IPRB_SRC_EXT2 = 5'h0f,
    IPRB_SRC_UART2_RX = 5'h10,
    IPRB_SRC_UART2_TX = 5'h11
  } iprb_src_e;

endpackage

// [core/iprb_reg16.sv]
// Purpose: one 16-bit priority register with a fixed implemented-bit mask
// Assumes: single clock, asynchronous active-low reset
// Notes: unimplemented bits are constant zero, never stored
`timescale 1ns/1ps
module iprb_reg16 #(
  parameter logic [15:0] MASK = 16'hffff,
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic wr_en_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] value_out
);

  logic [15:0] value_reg;
  logic [15:0] value_next;

  // a reset value on a separator bit could never be read back, and the first write drops it
  if ((RESET_VALUE & ~MASK) != 16'h0000) begin : g_bad_reset
    $error("reset value sets unimplemented bits");
  end

  // masked write
  // masking here keeps separator bits out of the fields entirely
  assign value_next = wr_en_in ? (wdata_in & MASK) : value_reg;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value_out = value_reg & MASK;

endmodule

// [verification/iprb_bank_asserts.sv]
// Purpose: port assertions for the interrupt priority bank
// Assumes: one clock, asynchronous active-low reset
// Notes: a helper flop keeps the previous cycle's write data for the field checks
`timescale 1ns/1ps
module iprb_bank_asserts (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [2:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic [17:0] src_enable_out,
  input wire logic [53:0] src_level_out,
  input wire logic [53:0] src_gated_level_out,
  input wire logic [17:0] src_active_out
);
  logic [15:0] wd_reg;
  logic [11:0] four_w;
  logic [17:0] act_w;
  logic [53:0] gat_w;
  // keep write data, since a slice of a past value is not portable
  always_ff @(posedge clk_in) wd_reg <= wdata_in;
  assign four_w = {wd_reg[14:12], wd_reg[10:8], wd_reg[6:4], wd_reg[2:0]};
  // expected gating per source: zero level or cleared enable blocks it
  for (genvar i = 0; i < 18; i++) begin : g_src
    assign act_w[i] = src_enable_out[i] & (|src_level_out[3*i+:3]);
    assign gat_w[3*i+:3] = act_w[i] ? src_level_out[3*i+:3] : 3'h0;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_read_idle_zero: assert property (!rd_in |=> rdata_out == 16'h0)
    else $error("read data not zero outside answer cycle");
  a_unmapped_read: assert property (rd_in && addr_in == 3'h7 |=> rdata_out == 16'h0)
    else $error("unmapped read not zero");
  a_first_map: assert property (wr_in && addr_in == 3'h0 |=>
    src_level_out[8:0] == four_w[8:0]) else $error("first register fields misplaced");
  a_second_map: assert property (wr_in && addr_in == 3'h1 |=>
    src_level_out[17:9] == {four_w[11:9], four_w[5:0]}) else $error("second register misplaced");
  a_third_map: assert property (wr_in && addr_in == 3'h2 |=> src_level_out[29:18] == four_w)
    else $error("third register fields misplaced");
  a_fourth_map: assert property (wr_in && addr_in == 3'h3 |=> src_level_out[41:30] == four_w)
    else $error("fourth register fields misplaced");
  a_fifth_map: assert property (wr_in && addr_in == 3'h4 |=> src_level_out[53:42] == four_w)
    else $error("fifth register fields misplaced");
  a_level_hold: assert property (!wr_in |=> $stable(src_level_out))
    else $error("levels changed without a write");
  a_active_gate: assert property (src_active_out == act_w)
    else $error("active flags wrong");
  a_gated_level: assert property (src_gated_level_out == gat_w)
    else $error("gated levels wrong");
  a_enable_write: assert property (wr_in && addr_in == 3'h5 |=>
    src_enable_out[15:0] == wd_reg) else $error("enable write not taken");
  a_enable_high: assert property (wr_in && addr_in == 3'h6 |=>
    src_enable_out[17:16] == wd_reg[1:0]) else $error("high enable write not taken");
  c_fifth_write: cover property (wr_in && addr_in == 3'h4);
  c_unmapped_read: cover property (rd_in && addr_in == 3'h7);
  c_source_active: cover property (src_active_out != 18'h0);
endmodule
bind iprb_bank iprb_bank_asserts iprb_bank_asserts_i (.clk_in(clk_in), .resetn_in(resetn_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .src_enable_out(src_enable_out), .src_level_out(src_level_out),
  .src_gated_level_out(src_gated_level_out), .src_active_out(src_active_out));

// [verification/iprb_bank_tb_top.sv]
// Purpose: self-checking bench for the interrupt priority bank
// Assumes: 200 MHz clock, reset held 12 cycles
// Notes: expected levels come from a shadow the bench keeps per write
`timescale 1ns/1ps
module iprb_bank_tb_top;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [15:0] wdata_in = 16'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic [17:0] en_w, act_w;
  logic [53:0] lvl_w, gat_w, lvl_exp;
  logic [15:0] mask_a [8] = '{iprb_pkg::IPRB_MASK_REG3, iprb_pkg::IPRB_MASK_REG4,
    iprb_pkg::IPRB_MASK_FOUR, iprb_pkg::IPRB_MASK_FOUR, iprb_pkg::IPRB_MASK_FOUR,
    iprb_pkg::IPRB_MASK_ENA_LO, iprb_pkg::IPRB_MASK_ENA_HI, 16'h0000};
  logic [15:0] rst_a [8] = '{iprb_pkg::IPRB_RST_REG3, iprb_pkg::IPRB_RST_REG4,
    iprb_pkg::IPRB_RST_FOUR, iprb_pkg::IPRB_RST_FOUR, iprb_pkg::IPRB_RST_FOUR,
    16'h0000, 16'h0000, 16'h0000};
  int fail_count = 0;
  int checks = 0;
  iprb_bank iprb_bank_i (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .src_enable_out(en_w), .src_level_out(lvl_w), .src_gated_level_out(gat_w),
    .src_active_out(act_w));
  // free-running clock, 5 ns period
  initial forever #2.5 clk_in = ~clk_in;
  task automatic cmp(input logic [53:0] got, input logic [53:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one write cycle, then levels compared with the shadow
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
    if (a == 3'h0) lvl_exp[8:0] = {d[10:8], d[6:4], d[2:0]};
    if (a == 3'h1) lvl_exp[17:9] = {d[14:12], d[6:4], d[2:0]};
    if (a inside {3'h2, 3'h3, 3'h4})
      lvl_exp[18+12*(int'(a)-2)+:12] = {d[14:12], d[10:8], d[6:4], d[2:0]};
    cmp(lvl_w, lvl_exp);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    cmp({38'h0, rdata_out}, {38'h0, e});
  endtask
  // a reset in mid-run is raised on a clock edge like every other input
  task automatic do_reset();
    if (resetn_in) @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    cmp(lvl_w, {18{iprb_pkg::IPRB_LVL_RESET}});
    resetn_in <= 1'b1;
    lvl_exp = {18{iprb_pkg::IPRB_LVL_RESET}};
  endtask
  task automatic t_reset();
    for (int a = 0; a < 8; a++) rd(3'(a), rst_a[a]);
    cmp({36'h0, act_w}, 54'h0);
    cmp(gat_w, 54'h0);
    $display("test reset values done");
  endtask
  // all ones then all zeros, unmapped place included
  task automatic t_masks();
    for (int a = 0; a < 8; a++) begin
      wr(3'(a), 16'hffff);
      if (a == 6) cmp({36'h0, en_w}, {36'h0, 2'h3, 16'h0});
      rd(3'(a), mask_a[a]);
      wr(3'(a), 16'h0000);
      rd(3'(a), 16'h0000);
    end
    $display("test masks done");
  endtask
  task automatic t_fields();
    for (int a = 0; a < 5; a++) wr(3'(a), 16'hb5e2 + 16'h1357 * 16'(a));
    for (int a = 0; a < 5; a++) rd(3'(a), (16'hb5e2 + 16'h1357 * 16'(a)) & mask_a[a]);
    $display("test field map done");
  endtask
  // every code on one enabled source, then its enable cleared
  task automatic t_codes();
    for (int a = 0; a < 5; a++) wr(3'(a), 16'h0000);
    wr(3'h5, 16'h4000);
    cmp({36'h0, en_w}, {38'h0, 16'h4000});
    for (int c = 0; c < 8; c++) begin
      wr(3'h4, 16'(c));
      cmp({36'h0, act_w}, {36'h0, 3'h0, c != 0, 14'h0});
      cmp(gat_w, {9'h0, 3'(c), 42'h0});
    end
    wr(3'h5, 16'h0000);
    cmp({36'h0, act_w}, 54'h0);
    cmp(gat_w, 54'h0);
    $display("test codes done");
  endtask
  task automatic final_report();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    final_report();
  end
  initial begin
    do_reset();
    t_reset();
    t_masks();
    t_fields();
    t_codes();
    do_reset();
    t_reset();
    final_report();
  end
endmodule
